/* design/afeon_pkg.sv */
// constants, types and enumerations shared by the frequency list and
// other-network flag manager and its frequency text converter
// assumes ASCII command bytes arriving on the system clock
package afeon_pkg;
	localparam int AF_MAX_ENTRIES = 25;
	localparam int AF_SLOTS = 8;
	localparam int LINKS = 4;
	localparam int NAME_LEN = 8;
	localparam logic [5:0] AF_CAP = 6'h19;
	localparam logic [15:0] FREQ_BASE = 16'h036b;
	localparam logic [15:0] FREQ_MIN = 16'h036c;
	localparam logic [15:0] FREQ_MAX = 16'h0438;
	localparam logic [10:0] FREQ_THOUSAND = 11'h3e8;
	localparam logic [7:0] AF_COUNT_BASE = 8'he0;
	localparam logic [7:0] AF_FILLER = 8'hcd;
	localparam logic METHOD_A = 1'b0;
	localparam logic METHOD_B = 1'b1;
	localparam logic METHOD_RESET = METHOD_A;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_1 = 8'h31;
	localparam logic [7:0] CH_4 = 8'h34;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_B = 8'h42;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] CH_I = 8'h49;
	localparam logic [7:0] CH_N = 8'h4e;
	localparam logic [7:0] CH_O = 8'h4f;
	localparam logic [7:0] CH_P = 8'h50;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_EQ = 8'h3d;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_DOT = 8'h2e;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_SP = 8'h20;
	typedef logic [AF_MAX_ENTRIES-1:0][7:0] afeon_list_t;
	typedef logic [NAME_LEN-1:0][7:0] afeon_name_t;
	typedef enum logic [3:0] {C_BAD, C_AF, C_AFS, C_TA, C_TP, C_PI, C_LAF,
		C_PS} afeon_cmd_e;
	typedef enum logic [1:0] {PS_PFX, PS_ARG, PS_SKIP} afeon_parse_e;
	typedef enum logic [1:0] {RP_IDLE, RP_TEXT, RP_SEP, RP_END} afeon_reply_e;
endpackage

/* design/afeon_freq_text.sv */
// converts a frequency code into its decimal text, e.g. 94.3 or 104.5
// assumes a code between 1 and 205 from a validated list
`timescale 1ns/1ns
`default_nettype none
module afeon_freq_text (
	// code in
	input wire logic [7:0] code,
	// text out, index 0 first
	output logic [4:0][7:0] chars,
	output logic [2:0] len
);
	import afeon_pkg::*;
	logic [10:0] f;
	logic [9:0] r;
	logic lead;
	always_comb begin
		f = 11'(code) + 11'(FREQ_BASE);
		lead = f >= FREQ_THOUSAND;
		r = lead ? 10'(f - FREQ_THOUSAND) : f[9:0];
		chars[0] = lead ? CH_1 : CH_0 + 8'(r / 10'd100);
		chars[1] = CH_0 + 8'(lead ? r / 10'd100 : (r / 10'd10) % 10'd10);
		chars[2] = lead ? CH_0 + 8'((r / 10'd10) % 10'd10) : CH_DOT;
		chars[3] = lead ? CH_DOT : CH_0 + 8'(r % 10'd10);
		chars[4] = lead ? CH_0 + 8'(r % 10'd10) : CH_SP;
		len = lead ? 3'h5 : 3'h4;
	end
endmodule
`default_nettype wire

/* design/afeon_ctrl.sv */
// ASCII command interpreter for alternative frequency lists and
// other-network traffic flags; one line per command, ended by CR
// assumes command bytes and af_next come from logic on clk
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - after reset method A is the active method.
// - method A sends one common list of up to 25 frequencies.
// - method B keeps up to eight lists of up to twelve pairs.
// - a method B list starts with its tuning frequency, then pairs.
// - pairs are sent as entered; ascending order means same programme.
// - descending order, as entered, marks other region or programme.
// - AF=A selects method A; slots are edited only under method A.
// - a list line loads the working list; a store line saves it to slot n.
// - method B cycles slots in order up to the empty slot.
// - bare AF query answers the method letter under method B.
// - reading an empty slot answers an empty line.
// - four link records: identifier, name, frequency, flags.
// - traffic programme and announcement flags are output as a pair.
// - an announcement on a linked service sets its flag to 1.
// - commands set and clear all four link announcement flags.
// - the first link flag also follows an external switch.
module afeon_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// command bytes
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic cmd_rejected,
	// reply bytes
	output logic resp_valid,
	output logic [7:0] resp_data,
	input wire logic resp_ready,
	// frequency stream
	input wire logic af_next,
	output logic af_pair_valid,
	output logic [7:0] af_first,
	output logic [7:0] af_second,
	output logic af_list_start,
	output logic af_method,
	// other-network links
	input wire logic announcement_switch,
	output logic [3:0] link_announcement,
	output logic [3:0] link_traffic_programme,
	output logic [3:0][15:0] link_identifier,
	output logic [3:0][7:0] link_alt_frequency,
	output var afeon_pkg::afeon_name_t link_name [afeon_pkg::LINKS]
);
	import afeon_pkg::*;
	afeon_parse_e pst, next_pst;
	afeon_cmd_e cmd, next_cmd;
	logic [47:0] pfx, next_pfx;
	logic [2:0] plen, next_plen, ndig, next_ndig, nlen, next_nlen;
	logic [1:0] link, next_link, fd, next_fd;
	logic [15:0] acc, next_acc;
	logic dot, next_dot, bad, next_bad, rej, next_rej;
	logic [7:0] letter, next_letter;
	logic [5:0] ecount, next_ecount;
	afeon_list_t stage, next_stage, work, next_work, alist, next_alist;
	logic [5:0] wlen, next_wlen, alen, next_alen;
	afeon_list_t slot [AF_SLOTS];
	afeon_list_t next_slot [AF_SLOTS];
	logic [5:0] slen [AF_SLOTS];
	logic [5:0] next_slen [AF_SLOTS];
	afeon_name_t nbuf, next_nbuf;
	afeon_name_t next_name [LINKS];
	logic method, next_method;
	logic [3:0] ta_sw, next_ta_sw, next_tp;
	logic [3:0][15:0] next_pi;
	logic [3:0][7:0] next_laf;
	logic start_letter, start_list, restart;
	logic [7:0] ch;
	logic dig, hexd, fin, dig1to8;
	logic [3:0] hv;
	logic [2:0] sidx;

	always_comb begin
		next_pst = pst; next_cmd = cmd; next_pfx = pfx; next_plen = plen;
		next_ndig = ndig; next_nlen = nlen; next_link = link; next_fd = fd;
		next_acc = acc; next_dot = dot; next_bad = bad; next_rej = rej;
		next_letter = letter; next_ecount = ecount; next_stage = stage;
		next_work = work; next_wlen = wlen; next_alist = alist;
		next_alen = alen; next_slot = slot; next_slen = slen;
		next_nbuf = nbuf; next_name = link_name; next_method = method;
		next_ta_sw = ta_sw; next_tp = link_traffic_programme;
		next_pi = link_identifier; next_laf = link_alt_frequency;
		start_letter = 1'b0; start_list = 1'b0; restart = 1'b0;
		ch = cmd_data;
		dig = ch >= CH_0 && ch <= CH_9;
		hexd = dig || (ch >= CH_A && ch <= CH_F);
		hv = dig ? ch[3:0] : 4'(ch[3:0] + 4'h9);
		fin = 1'b0;
		dig1to8 = ndig != 3'h0 && !dot && acc >= 16'h1 && acc <= 16'h8;
		sidx = 3'(acc - 16'h1);
		if (cmd_valid && cmd_ready) begin
			case (pst)
				PS_PFX: begin
					if (ch == CH_CR) begin
						if (plen == 3'h2 && pfx[15:0] == {CH_A, CH_F}) begin
							start_letter = method == METHOD_B;
							start_list = method == METHOD_A;
						end else if (plen == 3'h3 &&
							pfx[23:0] == {CH_STAR, CH_A, CH_F}) begin
							if (method == METHOD_A) begin
								next_alist = work;
								next_alen = wlen;
							end
							restart = 1'b1;
							next_rej = 1'b0;
						end else if (plen != 3'h0) begin
							next_rej = 1'b1;
						end
						next_plen = 3'h0;
					end else if (ch == CH_EQ) begin
						next_cmd = C_BAD;
						if (plen == 3'h2 && pfx[15:0] == {CH_A, CH_F})
							next_cmd = C_AF;
						else if (plen == 3'h3 && pfx[23:0] == {CH_STAR, CH_A, CH_F})
							next_cmd = C_AFS;
						else if (plen == 3'h6 && pfx[47:24] == {CH_E, CH_O, CH_N} &&
							pfx[23:16] >= CH_1 && pfx[23:16] <= CH_4) begin
							case (pfx[15:0])
								{CH_T, CH_A}: next_cmd = C_TA;
								{CH_T, CH_P}: next_cmd = C_TP;
								{CH_P, CH_I}: next_cmd = C_PI;
								{CH_A, CH_F}: next_cmd = C_LAF;
								{CH_P, CH_S}: next_cmd = C_PS;
								default: next_cmd = C_BAD;
							endcase
						end
						next_link = 2'(pfx[17:16] - 2'h1);
						next_acc = 16'h0; next_ndig = 3'h0; next_dot = 1'b0;
						next_fd = 2'h0; next_bad = 1'b0; next_letter = 8'h0;
						next_ecount = 6'h0; next_nlen = 3'h0;
						next_nbuf = {NAME_LEN{CH_SP}};
						next_pst = next_cmd == C_BAD ? PS_SKIP : PS_ARG;
						next_plen = 3'h0;
					end else if (ch != CH_LF) begin
						next_pfx = {pfx[39:0], ch};
						if (plen != 3'h7)
							next_plen = plen + 3'h1;
					end
				end
				PS_ARG: begin
					fin = ch == CH_CR || (ch == CH_COMMA && cmd == C_AF);
					if (ch == CH_CR || ch == CH_LF) begin
					end else if (cmd == C_PS) begin
						if (ecount == 6'(NAME_LEN)) begin
							next_bad = 1'b1;
						end else begin
							next_nbuf[nlen] = ch;
							next_nlen = nlen + 3'h1;
							next_ecount = ecount + 6'h1;
						end
					end else if (letter != 8'h0) begin
						next_bad = 1'b1;
					end else if (cmd == C_PI) begin
						next_bad = bad || !hexd;
						next_acc = {acc[11:0], hv};
						next_ndig = ndig == 3'h7 ? ndig : ndig + 3'h1;
					end else if (dig) begin
						next_acc = 16'(acc * 16'ha + 16'(ch[3:0]));
						next_ndig = ndig == 3'h7 ? ndig : ndig + 3'h1;
						if (dot && fd != 2'h3)
							next_fd = fd + 2'h1;
					end else if (ch == CH_DOT && !dot &&
						(cmd == C_AF || cmd == C_LAF)) begin
						next_dot = 1'b1;
					end else if ((ch == CH_A || ch == CH_B) && cmd == C_AF &&
						ndig == 3'h0 && ecount == 6'h0 && !dot) begin
						next_letter = ch;
					end else if (!fin) begin
						next_bad = 1'b1;
					end
					if (fin && (cmd == C_AF || cmd == C_LAF)) begin
						if (ndig != 3'h0 && dot) begin
							if (fd != 2'h1 || acc < FREQ_MIN || acc > FREQ_MAX ||
								ecount == AF_CAP) begin
								next_bad = 1'b1;
							end else begin
								next_stage[ecount[4:0]] = 8'(acc - FREQ_BASE);
								next_ecount = ecount + 6'h1;
							end
						end else if (ch == CH_COMMA) begin
							next_bad = 1'b1;
						end
						next_acc = 16'h0; next_ndig = 3'h0;
						next_dot = 1'b0; next_fd = 2'h0;
					end
					if (ch == CH_CR) begin
						next_pst = PS_PFX;
						next_rej = next_bad;
						if (!next_bad) begin
							case (cmd)
								C_AF: begin
									if (letter == CH_A) begin
										next_method = METHOD_A;
									end else if (letter == CH_B) begin
										next_method = METHOD_B;
										restart = 1'b1;
									end else if (ndig != 3'h0 && !dot) begin
										if (dig1to8 && method == METHOD_A &&
											ecount == 6'h0) begin
											next_work = slot[sidx];
											next_wlen = slen[sidx];
										end else begin
											next_rej = 1'b1;
										end
									end else begin
										next_work = next_stage;
										next_wlen = next_ecount;
									end
								end
								C_AFS: begin
									if (dig1to8 && method == METHOD_A) begin
										next_slot[sidx] = work;
										next_slen[sidx] = wlen;
									end else begin
										next_rej = 1'b1;
									end
								end
								C_TA: begin
									next_rej = ndig != 3'h1 || acc > 16'h1;
									if (!next_rej)
										next_ta_sw[link] = acc[0];
								end
								C_TP: begin
									next_rej = ndig != 3'h1 || acc > 16'h1;
									if (!next_rej)
										next_tp[link] = acc[0];
								end
								C_PI: begin
									next_rej = ndig != 3'h4;
									if (!next_rej)
										next_pi[link] = acc;
								end
								C_LAF: begin
									next_rej = next_ecount != 6'h1;
									if (!next_rej)
										next_laf[link] = next_stage[0];
								end
								C_PS: next_name[link] = nbuf;
								default: next_rej = 1'b1;
							endcase
						end
					end
				end
				PS_SKIP: begin
					if (ch == CH_CR) begin
						next_pst = PS_PFX;
						next_rej = 1'b1;
					end
				end
				default: next_pst = PS_PFX;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pst <= PS_PFX; cmd <= C_BAD; pfx <= 48'h0; plen <= 3'h0;
			ndig <= 3'h0; nlen <= 3'h0; link <= 2'h0; fd <= 2'h0;
			acc <= 16'h0; dot <= 1'b0; bad <= 1'b0; rej <= 1'b0;
			letter <= 8'h0; ecount <= 6'h0; stage <= '0; work <= '0;
			wlen <= 6'h0; alist <= '0; alen <= 6'h0;
			slot <= '{default: '0}; slen <= '{default: '0};
			nbuf <= '0; link_name <= '{default: '0};
			method <= METHOD_RESET;
			ta_sw <= 4'h0; link_traffic_programme <= 4'h0;
			link_identifier <= '0; link_alt_frequency <= '0;
		end else begin
			pst <= next_pst; cmd <= next_cmd; pfx <= next_pfx;
			plen <= next_plen; ndig <= next_ndig; nlen <= next_nlen;
			link <= next_link; fd <= next_fd; acc <= next_acc;
			dot <= next_dot; bad <= next_bad; rej <= next_rej;
			letter <= next_letter; ecount <= next_ecount;
			stage <= next_stage; work <= next_work; wlen <= next_wlen;
			alist <= next_alist; alen <= next_alen; slot <= next_slot;
			slen <= next_slen; nbuf <= next_nbuf; link_name <= next_name;
			method <= next_method; ta_sw <= next_ta_sw;
			link_traffic_programme <= next_tp;
			link_identifier <= next_pi; link_alt_frequency <= next_laf;
		end
	end

	// external announcement switch for the first link
	logic sw_meta, sw_sync;
	always_ff @(posedge clk) begin
		if (rst) begin
			sw_meta <= 1'b0; sw_sync <= 1'b0; link_announcement <= 4'h0;
		end else begin
			sw_meta <= announcement_switch;
			sw_sync <= sw_meta;
			link_announcement <= ta_sw | {3'h0, sw_sync};
		end
	end

	// frequency stream cycler
	logic [2:0] cs, next_cs;
	logic [4:0] pos, next_pos;
	logic [7:0] next_first, next_second;
	afeon_list_t lst;
	logic [5:0] n;
	always_comb begin
		next_cs = cs; next_pos = pos;
		next_first = af_first; next_second = af_second;
		lst = method == METHOD_B ? slot[cs] : alist;
		n = method == METHOD_B ? slen[cs] : alen;
		if (restart) begin
			next_cs = 3'h0;
			next_pos = 5'h0;
		end else if (af_next) begin
			// pair order kept as entered
			next_first = pos == 5'h0 ? AF_COUNT_BASE + 8'(n) :
				6'(pos) <= n ? lst[5'(pos - 5'h1)] : AF_FILLER;
			next_second = 6'(pos) + 6'h1 <= n ? lst[pos] : AF_FILLER;
			next_pos = 5'(pos + 5'h2);
			if (6'(pos) + 6'h1 >= n) begin
				next_pos = 5'h0;
				if (method == METHOD_B) begin
					// lists follow one another up to the empty slot
					next_cs = (cs == 3'h7 || slen[3'(cs + 3'h1)] == 6'h0) ?
						3'h0 : 3'(cs + 3'h1);
				end
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			cs <= 3'h0; pos <= 5'h0; af_first <= 8'h0; af_second <= 8'h0;
			af_pair_valid <= 1'b0; af_list_start <= 1'b1;
			af_method <= METHOD_RESET; cmd_rejected <= 1'b0;
		end else begin
			cs <= next_cs; pos <= next_pos; af_first <= next_first;
			af_second <= next_second; af_pair_valid <= af_next && !restart;
			af_list_start <= next_pos == 5'h0; af_method <= next_method;
			cmd_rejected <= next_rej;
		end
	end

	// reply sender
	afeon_reply_e rs, next_rs;
	logic [4:0] ri, next_ri;
	logic [2:0] rdp, next_rdp;
	logic next_valid, next_ready;
	logic [7:0] next_data;
	logic [4:0][7:0] txt;
	logic [2:0] tlen;
	afeon_freq_text u_text (
		.code(work[ri]),
		.chars(txt),
		.len(tlen)
	);
	always_comb begin
		next_rs = rs; next_ri = ri; next_rdp = rdp; next_data = resp_data;
		next_valid = resp_valid && !resp_ready;
		if (start_letter) begin
			next_data = method == METHOD_B ? CH_B : CH_A;
			next_valid = 1'b1;
			next_rs = RP_END;
		end else if (start_list) begin
			next_ri = 5'h0; next_rdp = 3'h0;
			next_rs = wlen == 6'h0 ? RP_END : RP_TEXT;
		end else if (!next_valid) begin
			case (rs)
				RP_TEXT: begin
					next_data = txt[rdp];
					next_valid = 1'b1;
					next_rdp = rdp + 3'h1;
					if (rdp == 3'(tlen - 3'h1)) begin
						next_rdp = 3'h0;
						next_rs = RP_SEP;
					end
				end
				RP_SEP: begin
					next_valid = 1'b1;
					next_data = CH_COMMA;
					next_ri = ri + 5'h1;
					next_rs = RP_TEXT;
					if (6'(ri) + 6'h1 == wlen) begin
						next_data = CH_CR;
						next_rs = RP_IDLE;
					end
				end
				RP_END: begin
					next_valid = 1'b1;
					next_data = CH_CR;
					next_rs = RP_IDLE;
				end
				RP_IDLE: next_rs = RP_IDLE;
				default: next_rs = RP_IDLE;
			endcase
		end
		next_ready = next_rs == RP_IDLE && !next_valid;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			rs <= RP_IDLE; ri <= 5'h0; rdp <= 3'h0; resp_valid <= 1'b0;
			resp_data <= 8'h0; cmd_ready <= 1'b0;
		end else begin
			rs <= next_rs; ri <= next_ri; rdp <= next_rdp;
			resp_valid <= next_valid; resp_data <= next_data;
			cmd_ready <= next_ready;
		end
	end
endmodule
`default_nettype wire

/* tb/afeon_ctrl_checker.sv */
// port checker for the frequency list and link flag manager
// assumes binding to afeon_ctrl, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module afeon_ctrl_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// command and reply
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ready,
	input wire logic cmd_rejected,
	input wire logic resp_valid,
	input wire logic [7:0] resp_data,
	input wire logic resp_ready,
	// stream and links
	input wire logic af_next,
	input wire logic af_pair_valid,
	input wire logic [7:0] af_first,
	input wire logic af_list_start,
	input wire logic af_method,
	input wire logic announcement_switch,
	input wire logic [3:0] link_announcement
);
	import afeon_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	logic cr_taken;
	assign cr_taken = cmd_valid && cmd_ready && cmd_data == CH_CR;
	AST_RESET_STATE: assert property (
		$fell(rst) |-> af_method == METHOD_A && af_list_start && !resp_valid)
		else $error("state after reset wrong");
	AST_PAIR_ANSWER: assert property (
		af_next && !cr_taken && !$past(cr_taken) |=> af_pair_valid)
		else $error("pair request not answered");
	AST_PAIR_CAUSE: assert property (
		af_pair_valid |-> $past(af_next))
		else $error("pair without request");
	AST_LIST_HEAD: assert property (
		af_pair_valid && $past(af_list_start) |->
		af_first[7:5] == 3'h7 && af_first[4:0] <= 5'h19)
		else $error("list does not open with its count");
	AST_METHOD_ON_LINE: assert property (
		!$past(rst) && $changed(af_method) |->
		$past(cr_taken) || $past(cr_taken, 2))
		else $error("method changed outside a line end");
	AST_REJECT_ON_LINE: assert property (
		!$past(rst) && $changed(cmd_rejected) |-> $past(cr_taken))
		else $error("refusal changed outside a line end");
	AST_BUSY_DURING_REPLY: assert property (
		resp_valid |-> !cmd_ready)
		else $error("command taken while reply pending");
	AST_REPLY_HOLD: assert property (
		resp_valid && !resp_ready |=> resp_valid && $stable(resp_data))
		else $error("reply byte dropped before taken");
	AST_SWITCH_FOLLOW: assert property (
		announcement_switch [*5] |-> link_announcement[0])
		else $error("first link flag ignores switch");
endmodule
bind afeon_ctrl afeon_ctrl_checker u_chk (.clk, .rst, .cmd_valid,
	.cmd_data, .cmd_ready, .cmd_rejected, .resp_valid, .resp_data,
	.resp_ready, .af_next, .af_pair_valid, .af_first, .af_list_start,
	.af_method, .announcement_switch, .link_announcement);
`default_nettype wire

/* tb/afeon_host_model.sv */
// host terminal model: sends command lines, takes reply bytes
// assumes the manager's valid/ready handshakes on clk
`timescale 1ns/1ns
`default_nettype none
module afeon_host_model (
	// clock
	input wire logic clk,
	// command bytes
	output logic cmd_valid,
	output logic [7:0] cmd_data,
	input wire logic cmd_ready,
	// reply bytes
	input wire logic resp_valid,
	output logic resp_ready,
	// stall control and hang flag
	input wire logic slow,
	output logic hang
);
	import afeon_pkg::*;
	integer seed;
	initial begin
		seed = 32'hd20c;
		cmd_valid = 1'b0;
		cmd_data = 8'h00;
		resp_ready = 1'b1;
		hang = 1'b0;
	end
	// reply side stalls at random when slow
	always @(posedge clk) begin
		#2 resp_ready = !slow || ($random(seed) & 1) == 0;
	end
	// byte held until the edge that samples ready high
	task automatic send_byte(input logic [7:0] b);
		int n;
		n = 0;
		cmd_valid = 1'b1;
		cmd_data = b;
		@(posedge clk);
		while (!cmd_ready && n < 400) begin
			n++;
			@(posedge clk);
		end
		if (n >= 400)
			hang = 1'b1;
		#2;
	endtask
	task automatic send_line(input string t);
		for (int i = 0; i < t.len(); i++)
			send_byte(t[i]);
		send_byte(CH_CR);
		cmd_valid = 1'b0;
		cmd_data = ~cmd_data;
	endtask
endmodule
`default_nettype wire

/* tb/afeon_ctrl_test.sv */
// self-checking bench for the frequency list and link flag manager
// assumes the host model sends lines; pairs and links driven here
`timescale 1ns/1ns
`default_nettype none
module afeon_ctrl_test;
	import afeon_pkg::*;
	logic clk, rst, af_next, announcement_switch, slow, hang;
	logic cmd_valid, cmd_ready, cmd_rejected, resp_valid, resp_ready;
	logic [7:0] cmd_data, resp_data, af_first, af_second;
	logic af_pair_valid, af_list_start, af_method;
	logic [3:0] link_announcement, link_traffic_programme;
	logic [3:0][15:0] link_identifier;
	logic [3:0][7:0] link_alt_frequency;
	afeon_name_t link_name [LINKS];
	logic [7:0] exp_resp[$];
	logic [15:0] exp_pair[$];
	logic [7:0] c [3];
	int failures, num_checks, seed, t;
	string s, sto;
	afeon_ctrl u_dut (.clk, .rst, .cmd_valid, .cmd_data, .cmd_ready,
		.cmd_rejected, .resp_valid, .resp_data, .resp_ready, .af_next,
		.af_pair_valid, .af_first, .af_second, .af_list_start, .af_method,
		.announcement_switch, .link_announcement, .link_traffic_programme,
		.link_identifier, .link_alt_frequency, .link_name);
	afeon_host_model u_host (.clk, .cmd_valid, .cmd_data, .cmd_ready,
		.resp_valid, .resp_ready, .slow, .hang);
	always #10 clk = ~clk;
	task automatic end_sim;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic line(input string l, input logic rej);
		u_host.send_line(l);
		repeat (3) @(posedge clk);
		#2 cmp8({7'h00, cmd_rejected}, {7'h00, rej});
	endtask
	task automatic query(input string q);
		int n;
		n = 0;
		for (int i = 0; i < q.len(); i++)
			exp_resp.push_back(q[i]);
		exp_resp.push_back(CH_CR);
		u_host.send_line("AF");
		while (exp_resp.size() > 0 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n >= 400) begin
			failures++;
			end_sim();
		end
		#2;
	endtask
	task automatic pair(input logic [15:0] p);
		exp_pair.push_back(p);
		af_next = 1'b1;
		@(posedge clk);
		#2 af_next = 1'b0;
		@(posedge clk);
		#2;
	endtask
	// results taken off the queues as they appear
	always @(posedge clk) begin
		if (resp_valid && resp_ready)
			cmp8(resp_data, exp_resp.size() ? exp_resp.pop_front() : 8'hxx);
		if (af_pair_valid)
			cmp16({af_first, af_second},
				exp_pair.size() ? exp_pair.pop_front() : 16'hxxxx);
		if (hang) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		af_next = 1'b0;
		announcement_switch = 1'b0;
		slow = 1'b0;
		failures = 0;
		num_checks = 0;
		seed = 32'hd20c;
		sto = "*";
		repeat (10) @(posedge clk);
		#2 rst = 1'b0;
		@(posedge clk);
		#2 cmp8({7'h00, af_method}, {7'h00, METHOD_A});
		s = "";
		for (int i = 0; i < 3; i++) begin
			t = 876 + ({$random(seed)} % 205);
			c[i] = 8'(t - 875);
			if (i > 0)
				s = {s, ","};
			s = {s, $sformatf("%0d.%0d", t / 10, t % 10)};
		end
		slow = 1'b1;
		line({"AF=", s}, 1'b0);
		query(s);
		line({sto, "AF"}, 1'b0);
		pair({8'he3, c[0]});
		cmp8({7'h00, af_list_start}, 8'h00);
		pair({c[1], c[2]});
		cmp8({7'h00, af_list_start}, 8'h01);
		pair({8'he3, c[0]});
		slow = 1'b0;
		line("AF=95.8,95.8,91.2", 1'b0);
		line({sto, "AF=1"}, 1'b0);
		line("AF=91.2,91.2,94.3", 1'b0);
		line({sto, "AF=2"}, 1'b0);
		line("AF=", 1'b0);
		line({sto, "AF=3"}, 1'b0);
		line({sto, "AF=9"}, 1'b1);
		line("AF=B", 1'b0);
		cmp8({7'h00, af_method}, {7'h00, METHOD_B});
		query("B");
		pair(16'he353);
		pair(16'h5325);
		pair(16'he325);
		pair(16'h2544);
		pair(16'he353);
		line({sto, "AF=1"}, 1'b1);
		line("AF=1", 1'b1);
		line("AF=A", 1'b0);
		line("AF=2", 1'b0);
		query("91.2,91.2,94.3");
		line("AF=3", 1'b0);
		query("");
		s = "88.0";
		for (int i = 1; i < 26; i++)
			s = {s, ",88.0"};
		line({"AF=", s}, 1'b1);
		query("");
		line({"AF=", s.substr(5, s.len() - 1)}, 1'b0);
		for (int n = 0; n < 4; n++) begin
			line($sformatf("EON%0dTA=1", n + 1), 1'b0);
			cmp8({4'h0, link_announcement}, 8'(1 << n));
			line($sformatf("EON%0dTP=1", n + 1), 1'b0);
			cmp8({4'h0, link_traffic_programme}, 8'((2 << n) - 1));
			line($sformatf("EON%0dTA=0", n + 1), 1'b0);
			cmp8({4'h0, link_announcement}, 8'h00);
		end
		line("EON5TA=1", 1'b1);
		line($sformatf("EON%0dPI=25F1", 1), 1'b0);
		cmp16(link_identifier[0], 16'h25f1);
		line("EON2PI=22F1", 1'b0);
		cmp16(link_identifier[1], 16'h22f1);
		line("EON2AF=93.7", 1'b0);
		cmp8(link_alt_frequency[1], 8'h3e);
		line("EON3PS=CITY", 1'b0);
		cmp8(link_name[2][0], 8'h43);
		cmp8(link_name[2][4], CH_SP);
		line("EON3PS=CITYNAMES", 1'b1);
		cmp8(link_name[2][0], 8'h43);
		announcement_switch = 1'b1;
		repeat (6) @(posedge clk);
		#2 cmp8({4'h0, link_announcement}, 8'h01);
		announcement_switch = 1'b0;
		repeat (6) @(posedge clk);
		#2 cmp8({4'h0, link_announcement}, 8'h00);
		line("XAF=1", 1'b1);
		end_sim();
	end
endmodule
`default_nettype wire
